/* File: ipr_pkg.sv */
package ipr_pkg;

  localparam int unsigned IPR_NUM_SRC = 18;
  localparam int unsigned IPR_NUM_GROUPS = 6;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IPR_IDX_PRIO_LOW = 8'hA9;
  localparam logic [7:0] IPR_IDX_PRIO_HIGH = 8'hB9;
  localparam logic [7:0] IPR_IDX_PEND_FIVE = 8'hE8;
  localparam logic [7:0] IPR_IDX_STATUS = 8'hF0;
  localparam logic [7:0] IPR_IDX_MASK = 8'hF1;

  localparam logic [7:0] IPR_PRIO_LOW_RST = 8'h00;
  localparam logic [7:0] IPR_PRIO_HIGH_RST = 8'h00;
  localparam logic [1:0] IPR_MASK_RST = 2'h0;

  // Bit positions in the five-flag register and the source numbers they hold.
  localparam int unsigned IPR_FIVE_BITS = 5;
  localparam logic [4:0] IPR_FIVE_NUM [0:4] = '{5'h06, 5'h07, 5'h0E, 5'h0F, 5'h11};

  // Status register bits.
  localparam int unsigned IPR_ST_VECTOR = 0;
  localparam int unsigned IPR_ST_PREEMPT = 1;
  localparam int unsigned IPR_ST_BITS = 2;

  // Group of every source number, indexed by number.
  localparam logic [2:0] IPR_GROUP_OF [0:17] = '{
    3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1, 3'h2, 3'h0,
    3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h3, 3'h4, 3'h0, 3'h5};

  // Fixed tie-break order among equal levels, first entry wins.
  localparam logic [4:0] IPR_POLL_ORDER [0:17] = '{
    5'h00, 5'h10, 5'h08, 5'h01, 5'h09, 5'h02, 5'h0A, 5'h03, 5'h0B,
    5'h04, 5'h0C, 5'h05, 5'h0D, 5'h06, 5'h07, 5'h0E, 5'h0F, 5'h11};

  // Timer sources whose flags hardware clears on vectoring.
  localparam logic [4:0] IPR_NUM_TIMER1 = 5'h09;
  localparam logic [4:0] IPR_NUM_TIMER4 = 5'h0C;

endpackage : ipr_pkg

/* File: ipr_flag.sv */
`timescale 1ns/1ps

// One pending or status flag: a hardware set wins over any write or clear.
module ipr_flag (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic set_i,
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic wdata_i,
  // State
  output logic q_o
);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q_o <= 1'b0;
    else if (set_i)
      q_o <= 1'b1;
    else if (wr_i)
      q_o <= wdata_i;
    else if (clr_i)
      q_o <= 1'b0;
  end

endmodule : ipr_flag

/* File: ipr_resolver.sv */
`timescale 1ns/1ps

module ipr_resolver #(
  parameter int unsigned NUM_SRC = 18
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt sources, one-cycle event pulses indexed by source number
  input wire logic [17:0] irq_src_i,
  // Core side
  input wire logic irq_ack_i,
  input wire logic irq_reti_i,
  output logic irq_req_o,
  output logic [4:0] irq_num_o,
  output logic [1:0] irq_level_o,
  // Summary interrupt
  output logic irq_o
);

  generate
    if (NUM_SRC != ipr_pkg::IPR_NUM_SRC)
    begin : g_bad_param
      $error("ipr_resolver serves exactly eighteen sources");
    end
  endgenerate

  logic [7:0] prio_low_reg;
  logic [7:0] prio_high_reg;
  logic [1:0] mask_reg;
  logic [3:0] in_service_reg;
  logic [17:0] pend;
  logic [17:0] pend_wr;
  logic [17:0] pend_wdata;
  logic [17:0] pend_clr;
  logic [1:0] status;
  logic [1:0] status_set;
  logic [1:0] cur_lvl;
  logic cur_valid;
  logic [1:0] lvl_of [0:17];
  logic win_found;
  logic [4:0] win_num;
  logic [1:0] win_lvl;
  logic [4:0] five_rd;
  logic five_wr;
  logic [17:0] five_member;
  logic [7:0] bus_idx;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] rd_data;

  // Bus decode. A request is answered one cycle after it is seen, so the
  // ack drops on its own in the cycle after it was given.
  assign bus_idx = wb_adr_i[9:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign bus_rd = bus_req && !wb_we_i;
  // Only the five-flag register reaches the pending flags from the bus.
  assign five_wr = bus_wr && bus_idx == ipr_pkg::IPR_IDX_PEND_FIVE;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prio_low_reg <= ipr_pkg::IPR_PRIO_LOW_RST;
      prio_high_reg <= ipr_pkg::IPR_PRIO_HIGH_RST;
    end
    else if (bus_wr && bus_idx == ipr_pkg::IPR_IDX_PRIO_LOW)
      prio_low_reg <= wb_dat_i[7:0];
    else if (bus_wr && bus_idx == ipr_pkg::IPR_IDX_PRIO_HIGH)
      prio_high_reg <= wb_dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask_reg <= ipr_pkg::IPR_MASK_RST;
    else if (bus_wr && bus_idx == ipr_pkg::IPR_IDX_MASK)
      mask_reg <= wb_dat_i[1:0];
  end

  // Level of each source from its group's two priority bits.
  always_comb
  begin
    for (int n = 0; n < 18; n++)
    begin
      lvl_of[n] = {prio_high_reg[ipr_pkg::IPR_GROUP_OF[n]],
                   prio_low_reg[ipr_pkg::IPR_GROUP_OF[n]]};
    end
  end

  // Flag write and clear steering. Flags in the five-flag register are only
  // cleared by software, so that a handler can still see its own cause;
  // every other flag clears when the core vectors to it.
  always_comb
  begin
    pend_wr = '0;
    pend_wdata = '0;
    pend_clr = '0;
    five_rd = '0;
    five_member = '0;
    for (int b = 0; b < 5; b++)
    begin
      five_member[ipr_pkg::IPR_FIVE_NUM[b]] = 1'b1;
      pend_wr[ipr_pkg::IPR_FIVE_NUM[b]] = five_wr;
      pend_wdata[ipr_pkg::IPR_FIVE_NUM[b]] = wb_dat_i[b];
      five_rd[b] = pend[ipr_pkg::IPR_FIVE_NUM[b]];
    end
    for (int n = 0; n < 18; n++)
    begin
      if (irq_ack_i && irq_num_o == 5'(n) && !five_member[n])
        pend_clr[n] = 1'b1;
    end
  end

  generate
    for (genvar n = 0; n < 18; n++)
    begin : g_pend
      ipr_flag u_pend (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(irq_src_i[n]),
        .clr_i(pend_clr[n]),
        .wr_i(pend_wr[n]),
        .wdata_i(pend_wdata[n]),
        .q_o(pend[n])
      );
    end
  endgenerate

  // Level currently in service: highest set bit of the in-service mask.
  always_comb
  begin
    cur_valid = |in_service_reg;
    cur_lvl = 2'h0;
    for (int l = 0; l < 4; l++)
    begin
      if (in_service_reg[l])
        cur_lvl = 2'(l);
    end
  end

  // Highest eligible level first, then the fixed polling order.
  always_comb
  begin
    win_found = 1'b0;
    win_num = 5'h00;
    win_lvl = 2'h0;
    for (int l = 3; l >= 0; l--)
    begin
      for (int p = 0; p < 18; p++)
      begin
        if (!win_found && pend[ipr_pkg::IPR_POLL_ORDER[p]]
            && lvl_of[ipr_pkg::IPR_POLL_ORDER[p]] == 2'(l)
            && (!cur_valid || 2'(l) > cur_lvl))
        begin
          win_found = 1'b1;
          win_num = ipr_pkg::IPR_POLL_ORDER[p];
          win_lvl = 2'(l);
        end
      end
    end
  end

  // The request is withdrawn for one cycle after each vector so that the
  // next offer is computed from the updated in-service state.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_req_o <= 1'b0;
      irq_num_o <= 5'h00;
      irq_level_o <= 2'h0;
    end
    else
    begin
      irq_req_o <= win_found && !irq_ack_i && !irq_reti_i;
      irq_num_o <= win_num;
      irq_level_o <= win_lvl;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      in_service_reg <= 4'h0;
    else if (irq_ack_i && irq_req_o)
      in_service_reg <= in_service_reg | (4'h1 << irq_level_o);
    else if (irq_reti_i && cur_valid)
      in_service_reg <= in_service_reg & ~(4'h1 << cur_lvl);
  end

  assign status_set[ipr_pkg::IPR_ST_VECTOR] = irq_ack_i && irq_req_o;
  assign status_set[ipr_pkg::IPR_ST_PREEMPT] = irq_ack_i && irq_req_o && cur_valid;

  generate
    for (genvar s = 0; s < 2; s++)
    begin : g_status
      ipr_flag u_status (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(status_set[s]),
        .clr_i(bus_rd && bus_idx == ipr_pkg::IPR_IDX_STATUS),
        .wr_i(1'b0),
        .wdata_i(1'b0),
        .q_o(status[s])
      );
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(status & mask_reg);
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (bus_idx == ipr_pkg::IPR_IDX_PRIO_LOW)
      rd_data[7:0] = prio_low_reg;
    else if (bus_idx == ipr_pkg::IPR_IDX_PRIO_HIGH)
      rd_data[7:0] = prio_high_reg;
    else if (bus_idx == ipr_pkg::IPR_IDX_PEND_FIVE)
      rd_data[4:0] = five_rd;
    else if (bus_idx == ipr_pkg::IPR_IDX_STATUS)
      rd_data[1:0] = status;
    else if (bus_idx == ipr_pkg::IPR_IDX_MASK)
      rd_data[1:0] = mask_reg;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_rd ? rd_data : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  prio_reset_a: assert property (
    $past(rst_i) |-> prio_low_reg == 8'h00 && prio_high_reg == 8'h00)
    else $error("priority registers not zero after reset");

  level_form_a: assert property (
    irq_req_o && $stable(prio_low_reg) && $stable(prio_high_reg)
      |-> irq_level_o == {prio_high_reg[ipr_pkg::IPR_GROUP_OF[irq_num_o]],
                          prio_low_reg[ipr_pkg::IPR_GROUP_OF[irq_num_o]]})
    else $error("offered level does not match the group priority bits");

  no_lower_a: assert property (
    irq_req_o && $stable(in_service_reg) && cur_valid |-> irq_level_o > cur_lvl)
    else $error("request offered at or below the serviced level");

  preempt_record_a: assert property (
    irq_ack_i && irq_req_o && cur_valid
      |=> status[ipr_pkg::IPR_ST_PREEMPT] && in_service_reg != $past(in_service_reg))
    else $error("preemption not recorded");

  poll_order_a: assert property (
    pend[0] && pend[16] && lvl_of[0] == lvl_of[16] && in_service_reg == 4'h0
      |=> irq_num_o != 5'h10)
    else $error("tie not resolved in polling order");

  timer_clear_a: assert property (
    irq_ack_i && irq_num_o == ipr_pkg::IPR_NUM_TIMER1 && !irq_src_i[9] |=> !pend[9])
    else $error("timer flag not cleared on vectoring");

  timer_four_a: assert property (
    irq_ack_i && irq_num_o == ipr_pkg::IPR_NUM_TIMER4 && !irq_src_i[12] |=> !pend[12])
    else $error("fourth timer flag not cleared on vectoring");

  hw_wins_a: assert property (
    irq_src_i[17] && pend_wr[17] |=> pend[17])
    else $error("hardware set lost against a clear");

  flag_write_a: assert property (
    five_wr && irq_src_i == 18'h0
      |=> {27'h0, five_rd} == ($past(wb_dat_i) & 32'h0000_001F))
    else $error("five-flag write not stored");

  // Vectoring must leave a five-flag pending until software clears it.
  five_hold_a: assert property (
    irq_ack_i && irq_num_o == 5'h11 && pend[17] && !pend_wr[17] |=> pend[17])
    else $error("five-flag cleared by vectoring");

  // A read of status in the same cycle as a vector must not lose the event.
  status_keep_a: assert property (
    status_set[ipr_pkg::IPR_ST_VECTOR] |=> status[ipr_pkg::IPR_ST_VECTOR])
    else $error("vector status bit lost");

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");

  read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside an ack");

  // The summary interrupt lags the masked status by one register stage.
  irq_out_a: assert property (|(status & mask_reg) |=> irq_o)
    else $error("interrupt output missing for masked status");

  irq_idle_a: assert property (!(|(status & mask_reg)) |=> !irq_o)
    else $error("interrupt output high without masked status");

endmodule : ipr_resolver

/* File: ipr_core_model.sv */
`timescale 1ns/1ps

// Core stand-in: it takes an offered request one cycle after seeing it and records what it took.
// Holding en_i low models a core that is busy and leaves the offer standing.
module ipr_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Offer from the resolver
  input wire logic en_i,
  input wire logic req_i,
  input wire logic [4:0] num_i,
  input wire logic [1:0] lvl_i,
  // Vectoring
  output logic ack_o,
  output logic [4:0] num_o,
  output logic [1:0] lvl_o
);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      num_o <= 5'h00;
      lvl_o <= 2'h0;
    end
    else
    begin
      ack_o <= en_i && req_i && !ack_o;
      if (en_i && req_i && !ack_o)
      begin
        num_o <= num_i;
        lvl_o <= lvl_i;
      end
    end
  end
endmodule : ipr_core_model

/* File: interrupt_priority_resolver_test.sv */
`timescale 1ns/1ps

module interrupt_priority_resolver_test;
  logic clk_i;
  logic rst_i;
  logic cyc, stb, we, ack, reti, en, req, irq, core_ack;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rd;
  logic [17:0] src;
  logic [4:0] num, got_num;
  logic [1:0] lvl, got_lvl;
  int error_cnt = 0;
  int tests_run = 0;
  logic [4:0] poll_exp [0:12] = '{5'h00, 5'h10, 5'h08, 5'h01, 5'h09, 5'h02, 5'h0A, 5'h03,
    5'h0B, 5'h04, 5'h0C, 5'h05, 5'h0D};

  ipr_resolver #(.NUM_SRC(18)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_src_i(src), .irq_ack_i(core_ack),
    .irq_reti_i(reti), .irq_req_o(req), .irq_num_o(num), .irq_level_o(lvl), .irq_o(irq));
  ipr_core_model core (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .req_i(req), .num_i(num),
    .lvl_i(lvl), .ack_o(core_ack), .num_o(got_num), .lvl_o(got_lvl));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Entered just after a rising edge; returns one idle cycle after the release.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (n >= 20)
    begin
      error_cnt++;
      close_out();
    end
  endtask : bus

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic pulse(input logic [17:0] m);
    src <= m;
    @(posedge clk_i);
    src <= 18'h0;
    @(posedge clk_i);
  endtask : pulse

  task automatic ret;
    reti <= 1'b1;
    @(posedge clk_i);
    reti <= 1'b0;
    @(posedge clk_i);
  endtask : ret

  // Waits for the core to vector, checks what it took, optionally returns at once.
  task automatic serve(input logic [4:0] n_exp, input logic [1:0] l_exp, input logic back);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (core_ack !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      error_cnt++;
      close_out();
    end
    chk(got_num, n_exp);
    chk(got_lvl, l_exp);
    if (back)
      ret();
  endtask : serve

  initial
  begin
    rst_i = 1'b1;
    {cyc, stb, we, reti, en} = 5'h0;
    adr = 10'h000;
    sel = 4'hF;
    wdat = 32'h0;
    src = 18'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(ipr_pkg::IPR_IDX_PRIO_LOW, 32'h0);
    rdc(ipr_pkg::IPR_IDX_PRIO_HIGH, 32'h0);
    rdc(ipr_pkg::IPR_IDX_PEND_FIVE, 32'h0);
    bus(1'b1, ipr_pkg::IPR_IDX_PEND_FIVE, 32'h1F);
    rdc(ipr_pkg::IPR_IDX_PEND_FIVE, 32'h1F);
    repeat (3) @(posedge clk_i);
    chk(num, 32'h6);
    bus(1'b1, ipr_pkg::IPR_IDX_PEND_FIVE, 32'h0);
    rdc(ipr_pkg::IPR_IDX_PEND_FIVE, 32'h0);
    fork
      bus(1'b1, ipr_pkg::IPR_IDX_PEND_FIVE, 32'h0);
      begin
        src <= 18'h20000;
        @(posedge clk_i);
        src <= 18'h0;
      end
    join
    rdc(ipr_pkg::IPR_IDX_PEND_FIVE, 32'h10);
    bus(1'b1, ipr_pkg::IPR_IDX_PEND_FIVE, 32'h0);
    rdc(8'h10, 32'h0);
    rdc(ipr_pkg::IPR_IDX_STATUS, 32'h0);
    en <= 1'b1;
    pulse(18'h13F3F);
    for (int k = 0; k < 13; k++)
      serve(poll_exp[k], 2'h0, 1'b1);
    chk(req, 32'h0);
    // Levels by group 0..5 become 0, 1, 2, 3, 0, 1; bits 7:6 are set to show they do nothing.
    bus(1'b1, ipr_pkg::IPR_IDX_PRIO_LOW, 32'hEA);
    bus(1'b1, ipr_pkg::IPR_IDX_PRIO_HIGH, 32'hCC);
    rdc(ipr_pkg::IPR_IDX_PRIO_LOW, 32'hEA);
    pulse(18'h0003F);
    serve(5'h03, 2'h3, 1'b1);
    serve(5'h02, 2'h2, 1'b1);
    serve(5'h01, 2'h1, 1'b1);
    serve(5'h05, 2'h1, 1'b1);
    serve(5'h00, 2'h0, 1'b1);
    serve(5'h04, 2'h0, 1'b1);
    pulse(18'h00001);
    serve(5'h00, 2'h0, 1'b0);
    pulse(18'h00008);
    serve(5'h03, 2'h3, 1'b0);
    pulse(18'h00010);
    repeat (5) @(posedge clk_i);
    chk(req, 32'h0);
    ret();
    repeat (3) @(posedge clk_i);
    chk(req, 32'h0);
    ret();
    serve(5'h04, 2'h0, 1'b1);
    bus(1'b1, ipr_pkg::IPR_IDX_MASK, 32'h3);
    @(posedge clk_i);
    chk(irq, 32'h1);
    rdc(ipr_pkg::IPR_IDX_STATUS, 32'h3);
    repeat (2) @(posedge clk_i);
    chk(irq, 32'h0);
    bus(1'b1, ipr_pkg::IPR_IDX_MASK, 32'h0);
    pulse(18'h00004);
    serve(5'h02, 2'h2, 1'b1);
    repeat (2) @(posedge clk_i);
    chk(irq, 32'h0);
    rdc(ipr_pkg::IPR_IDX_STATUS, 32'h1);
    pulse(18'h20000);
    serve(5'h11, 2'h1, 1'b0);
    rdc(ipr_pkg::IPR_IDX_PEND_FIVE, 32'h10);
    bus(1'b1, ipr_pkg::IPR_IDX_PEND_FIVE, 32'h0);
    ret();
    chk(req, 32'h0);
    rdc(ipr_pkg::IPR_IDX_STATUS, 32'h1);
    close_out();
  end
endmodule : interrupt_priority_resolver_test
